/* File: src/usm_pkg.sv */
// register map, field positions and reset values of the serial port
package usm_pkg;
    localparam int          AW          = 3;
    localparam int          DW          = 8;
    localparam int          WW          = 9;
    localparam int          DEPTH       = 2;
    localparam logic [2:0]  OFS_CTRL    = 3'h0;
    localparam logic [2:0]  OFS_STAT    = 3'h1;
    localparam logic [2:0]  OFS_BAUD    = 3'h2;
    localparam logic [2:0]  OFS_TXH     = 3'h3;
    localparam logic [2:0]  OFS_RXD     = 3'h4;
    localparam logic [2:0]  OFS_IEN     = 3'h5;
    localparam logic [2:0]  OFS_FLAG    = 3'h6;
    // control register fields
    localparam int          B_MASTER    = 7;
    localparam int          B_TX9       = 6;
    localparam int          B_TXON      = 5;
    localparam int          B_POL       = 3;
    localparam int          B_TSRMT     = 1;
    localparam int          B_TXD9      = 0;
    // status register fields
    localparam int          B_PE        = 7;
    localparam int          B_RX9       = 6;
    localparam int          B_SNGL      = 5;
    localparam int          B_CONT      = 4;
    localparam int          B_OVFL      = 1;
    localparam int          B_RXD9      = 0;
    // interrupt enable register fields
    localparam int          B_RXIR      = 0;
    localparam int          B_TXIR      = 1;
    localparam int          B_PERI      = 6;
    localparam int          B_GLB       = 7;
    // flag register fields
    localparam int          B_RXFL      = 0;
    localparam int          B_TXFL      = 1;
    localparam logic [7:0]  RST_REG     = 8'h00;
    localparam logic [3:0]  RST_CNT     = 4'h0;
    localparam logic [3:0]  BITS8       = 4'h8;
    localparam logic [3:0]  BITS9       = 4'h9;
    typedef enum logic [1:0] {
        USM_IDLE  = 2'b00,
        USM_SHIFT = 2'b01,
        USM_DONE  = 2'b11
    } usm_state_e;
endpackage : usm_pkg

/* File: src/usm_rx_if.sv */
// signals between the port logic and its receive fifo
interface usm_rx_if;
    import usm_pkg::*;
    logic          push;
    logic          pop;
    logic          flush;
    logic [WW-1:0] wdata;
    logic [WW-1:0] head;
    logic          full;
    logic          empty;
    modport fifo (input push, pop, flush, wdata, output head, full, empty);
    modport user (output push, pop, flush, wdata, input head, full, empty);
endinterface : usm_rx_if

/* File: src/usm_rx_fifo.sv */
// two-entry receive fifo in flip-flops
module usm_rx_fifo
    import usm_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RESET_I,
    usm_rx_if.fifo    rx
);
    logic [WW-1:0] mem [DEPTH];
    logic          wp;
    logic          rp;
    logic [1:0]    cnt;

    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge CLK_I or posedge RESET_I) begin
            if (RESET_I) begin
                mem[g] <= '0;
            end else if (rx.push && !rx.full && wp == 1'(g)) begin
                mem[g] <= rx.wdata;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'd0;
        end else if (rx.flush) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'd0;
        end else begin
            if (rx.push && !rx.full) begin
                wp <= ~wp;
            end
            if (rx.pop && !rx.empty) begin
                rp <= ~rp;
            end
            cnt <= cnt + 2'(rx.push && !rx.full) - 2'(rx.pop && !rx.empty);
        end
    end

    assign rx.head  = mem[rp];
    assign rx.full  = (cnt == 2'(DEPTH));
    assign rx.empty = (cnt == 2'd0);
endmodule : usm_rx_fifo

/* File: src/usm_baud.sv */
// baud timer held in restart unless the master is shifting, one tick per serial half period
module usm_baud
    import usm_pkg::*;
(
    input  wire logic          CLK_I,
    input  wire logic          RESET_I,
    input  wire logic          restart_i,
    input  wire logic [DW-1:0] divisor_i,
    output logic               tick_o
);
    logic [DW-1:0] cnt;
    logic          half;

    // half period is 2*(n+1) clocks, full serial period 4*(n+1)
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cnt    <= '0;
            half   <= 1'b0;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            cnt    <= '0;
            half   <= 1'b0;
            tick_o <= 1'b0;
        end else if (cnt >= divisor_i) begin
            cnt    <= '0;
            half   <= ~half;
            tick_o <= half;
        end else begin
            cnt    <= cnt + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule : usm_baud

/* File: src/usm_top.sv */
// synchronous half-duplex serial port, clock master or clock slave
//
// Behaviour
// - master receive releases the data line driver
// - single receive clocks one character, self-clears
// - continuous receive clocks until enable cleared
// - clearing continuous mid-character aborts, stops clock
// - both enables, master: single clears after first
// - data sampled on trailing clock edge
// - finished character pushed into two-entry fifo
// - receive flag set while fifo not empty
// - slave never drives the clock line
// - data changes leading edge, valid trailing
// - third character sets overflow, fifo kept
// - overflow blocks reception, fifo still readable
// - overflow cleared by enable clear, or by read with continuous off
// - nine bits shifted, ninth read after low
// - receive interrupt gated by three enables
// - slave receive follows continuous enable only
// - slave transmit same as master transmit
// - polarity sets idle level and edges
// - holding register waits for shift register
// - divisor write restarts baud timer
// - port disable resets port, frees pins
module usm_top
    import usm_pkg::*;
(
    input  wire logic          CLK_I,
    input  wire logic          RESET_I,
    input  wire logic [AW-1:0] ADDR_I,
    input  wire logic [DW-1:0] WDATA_I,
    input  wire logic          WRITE_I,
    input  wire logic          READ_I,
    output logic      [DW-1:0] RDATA_O,
    input  wire logic          CK_I,
    output logic               CK_O,
    output logic               CK_OE_O,
    input  wire logic          DT_I,
    output logic               DT_O,
    output logic               DT_OE_O,
    output logic               IRQ_O
);
    usm_rx_if rx ();

    logic          clock_source_master;
    logic          nine_bit_transmit_enable;
    logic          transmit_enable;
    logic          clock_polarity;
    logic          transmit_ninth_bit;
    logic          port_enable;
    logic          nine_bit_receive_enable;
    logic          single_receive_enable;
    logic          continuous_receive_enable;
    logic          overflow_error_flag;
    logic          receive_ninth_bit;
    logic [DW-1:0] baud_divisor;
    logic [DW-1:0] transmit_holding_register;
    logic          txh_full;
    logic          receive_interrupt_enable;
    logic          transmit_interrupt_enable;
    logic          peripheral_interrupt_enable;
    logic          global_interrupt_enable;

    usm_state_e    st;
    logic [WW-1:0] shreg;
    logic [3:0]    bitcnt;
    logic          nine;
    logic          dir_rx;
    logic          sclk;
    logic          dt_out;
    logic          ck_m, ck_s, ck_d;
    logic          dt_m, dt_s;
    logic          tick;

    logic          rx_mode, tx_mode, lead, trail, last_bit;
    logic          load_tx, start_rx, abort, char_done;
    logic [WW-1:0] rx_word;

    // first stage feeds only the second
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ck_m <= 1'b0;
            ck_s <= 1'b0;
            ck_d <= 1'b0;
            dt_m <= 1'b0;
            dt_s <= 1'b0;
        end else begin
            ck_m <= CK_I;
            ck_s <= ck_m;
            ck_d <= ck_s;
            dt_m <= DT_I;
            dt_s <= dt_m;
        end
    end

    // slave ignores the single enable
    assign rx_mode  = clock_source_master
                    ? (single_receive_enable | continuous_receive_enable)
                    : continuous_receive_enable;
    assign tx_mode  = !rx_mode && transmit_enable;
    assign lead     = clock_source_master
                    ? (tick && st == USM_SHIFT && sclk == clock_polarity)
                    : (ck_s != ck_d && ck_d == clock_polarity);
    assign trail    = clock_source_master
                    ? (tick && st == USM_SHIFT && sclk != clock_polarity)
                    : (ck_s != ck_d && ck_s == clock_polarity);
    assign last_bit = (bitcnt == (nine ? BITS9 : BITS8) - 4'h1);
    assign load_tx  = st == USM_IDLE && tx_mode && txh_full;
    assign start_rx = st == USM_IDLE && !load_tx && rx_mode
                    && !overflow_error_flag;
    assign abort    = st == USM_SHIFT && dir_rx && !rx_mode;
    assign char_done = st == USM_DONE && dir_rx;
    assign rx_word  = nine ? shreg : {1'b0, shreg[WW-1:1]};

    assign rx.push  = char_done && !overflow_error_flag;
    assign rx.wdata = rx_word;
    assign rx.pop   = READ_I && ADDR_I == OFS_RXD;
    assign rx.flush = !port_enable;

    usm_rx_fifo u_fifo (
        .CLK_I   (CLK_I),
        .RESET_I (RESET_I),
        .rx      (rx.fifo)
    );

    // a new divisor takes effect at once
    usm_baud u_baud (
        .CLK_I     (CLK_I),
        .RESET_I   (RESET_I),
        .restart_i ((WRITE_I && ADDR_I == OFS_BAUD)
                    || st != USM_SHIFT || !clock_source_master),
        .divisor_i (baud_divisor),
        .tick_o    (tick)
    );

    // software configuration
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            clock_source_master         <= 1'b0;
            nine_bit_transmit_enable    <= 1'b0;
            transmit_enable             <= 1'b0;
            clock_polarity              <= 1'b0;
            transmit_ninth_bit          <= 1'b0;
            port_enable                 <= 1'b0;
            nine_bit_receive_enable     <= 1'b0;
            continuous_receive_enable   <= 1'b0;
            baud_divisor                <= RST_REG;
            receive_interrupt_enable    <= 1'b0;
            transmit_interrupt_enable   <= 1'b0;
            peripheral_interrupt_enable <= 1'b0;
            global_interrupt_enable     <= 1'b0;
        end else if (WRITE_I) begin
            if (ADDR_I == OFS_CTRL) begin
                clock_source_master      <= WDATA_I[B_MASTER];
                nine_bit_transmit_enable <= WDATA_I[B_TX9];
                transmit_enable          <= WDATA_I[B_TXON];
                clock_polarity           <= WDATA_I[B_POL];
                transmit_ninth_bit       <= WDATA_I[B_TXD9];
            end else if (ADDR_I == OFS_STAT) begin
                port_enable               <= WDATA_I[B_PE];
                nine_bit_receive_enable   <= WDATA_I[B_RX9];
                continuous_receive_enable <= WDATA_I[B_CONT];
            end else if (ADDR_I == OFS_BAUD) begin
                baud_divisor <= WDATA_I;
            end else if (ADDR_I == OFS_IEN) begin
                receive_interrupt_enable    <= WDATA_I[B_RXIR];
                transmit_interrupt_enable   <= WDATA_I[B_TXIR];
                peripheral_interrupt_enable <= WDATA_I[B_PERI];
                global_interrupt_enable     <= WDATA_I[B_GLB];
            end
        end
    end

    // single enable drops after one character in master mode only; a write in that cycle wins
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            single_receive_enable <= 1'b0;
        end else if (WRITE_I && ADDR_I == OFS_STAT) begin
            single_receive_enable <= WDATA_I[B_SNGL];
        end else if (char_done && clock_source_master) begin
            single_receive_enable <= 1'b0;
        end
    end

    // holding register, full flag set by write wins over load
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            transmit_holding_register <= RST_REG;
            txh_full                  <= 1'b0;
        end else if (!port_enable) begin
            txh_full <= 1'b0;
        end else if (WRITE_I && ADDR_I == OFS_TXH) begin
            transmit_holding_register <= WDATA_I;
            txh_full                  <= 1'b1;
        end else if (load_tx) begin
            txh_full <= 1'b0;
        end
    end

    // shift engine shared by master and slave
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            st     <= USM_IDLE;
            shreg  <= '0;
            bitcnt <= RST_CNT;
            nine   <= 1'b0;
            dir_rx <= 1'b0;
            dt_out <= 1'b0;
        end else if (!port_enable) begin
            st     <= USM_IDLE;
            bitcnt <= RST_CNT;
            dt_out <= 1'b0;
        end else begin
            case (st)
                USM_IDLE: begin
                    bitcnt <= RST_CNT;
                    if (load_tx) begin
                        shreg  <= {transmit_ninth_bit,
                                   transmit_holding_register};
                        nine   <= nine_bit_transmit_enable;
                        dir_rx <= 1'b0;
                        st     <= USM_SHIFT;
                    end else if (start_rx) begin
                        shreg  <= '0;
                        nine   <= nine_bit_receive_enable;
                        dir_rx <= 1'b1;
                        st     <= USM_SHIFT;
                    end
                end
                USM_SHIFT: begin
                    if (abort) begin
                        st <= USM_IDLE;
                    end else if (lead) begin
                        if (!dir_rx) begin
                            dt_out <= shreg[0];
                        end
                    end else if (trail) begin
                        if (dir_rx) begin
                            shreg <= {dt_s, shreg[WW-1:1]};
                        end else begin
                            shreg <= {1'b0, shreg[WW-1:1]};
                        end
                        bitcnt <= bitcnt + 4'h1;
                        if (last_bit) begin
                            st <= USM_DONE;
                        end
                    end
                end
                USM_DONE: begin
                    st <= USM_IDLE;
                end
                default: begin
                    st <= USM_IDLE;
                end
            endcase
        end
    end

    // master clock idles at the polarity level, forced idle on abort
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            sclk <= 1'b0;
        end else if (!clock_source_master || st != USM_SHIFT || abort) begin
            sclk <= clock_polarity;
        end else if (lead) begin
            sclk <= ~clock_polarity;
        end else if (trail) begin
            sclk <= clock_polarity;
        end
    end

    // overflow: set wins over every clear
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            overflow_error_flag <= 1'b0;
        end else if (char_done && rx.full) begin
            overflow_error_flag <= 1'b1;
        end else if (!port_enable) begin
            overflow_error_flag <= 1'b0;
        end else if (WRITE_I && ADDR_I == OFS_STAT && !WDATA_I[B_CONT]) begin
            overflow_error_flag <= 1'b0;
        end else if (rx.pop && !continuous_receive_enable) begin
            overflow_error_flag <= 1'b0;
        end
    end

    // ninth bit latched by the low-byte read
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            receive_ninth_bit <= 1'b0;
        end else if (rx.pop && !rx.empty) begin
            receive_ninth_bit <= rx.head[WW-1];
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RDATA_O <= RST_REG;
        end else if (!READ_I) begin
            RDATA_O <= RST_REG;
        end else if (ADDR_I == OFS_CTRL) begin
            RDATA_O <= {clock_source_master, nine_bit_transmit_enable,
                        transmit_enable, 1'b0, clock_polarity, 1'b0,
                        !(st != USM_IDLE && !dir_rx), transmit_ninth_bit};
        end else if (ADDR_I == OFS_STAT) begin
            RDATA_O <= {port_enable, nine_bit_receive_enable,
                        single_receive_enable, continuous_receive_enable,
                        2'b00, overflow_error_flag, receive_ninth_bit};
        end else if (ADDR_I == OFS_BAUD) begin
            RDATA_O <= baud_divisor;
        end else if (ADDR_I == OFS_TXH) begin
            RDATA_O <= transmit_holding_register;
        end else if (ADDR_I == OFS_RXD) begin
            RDATA_O <= rx.empty ? RST_REG : rx.head[DW-1:0];
        end else if (ADDR_I == OFS_IEN) begin
            RDATA_O <= {global_interrupt_enable,
                        peripheral_interrupt_enable, 4'h0,
                        transmit_interrupt_enable,
                        receive_interrupt_enable};
        end else if (ADDR_I == OFS_FLAG) begin
            RDATA_O <= {6'h00, !txh_full, !rx.empty};
        end else begin
            RDATA_O <= RST_REG;
        end
    end

    // pins and interrupt request
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            CK_O    <= 1'b0;
            CK_OE_O <= 1'b0;
            DT_O    <= 1'b0;
            DT_OE_O <= 1'b0;
            IRQ_O   <= 1'b0;
        end else begin
            CK_O    <= sclk;
            CK_OE_O <= port_enable && clock_source_master;
            DT_O    <= dt_out;
            DT_OE_O <= port_enable && tx_mode;
            IRQ_O   <= global_interrupt_enable
                       && peripheral_interrupt_enable
                       && ((receive_interrupt_enable && !rx.empty)
                           || (transmit_interrupt_enable
                               && transmit_enable && !txh_full));
        end
    end
endmodule : usm_top

/* File: verification/usm_checker.sv */
// assertions on the serial port pins and register port
module usm_checker
    import usm_pkg::*;
(
    input wire logic          CLK_I,
    input wire logic          RESET_I,
    input wire logic [AW-1:0] ADDR_I,
    input wire logic [DW-1:0] WDATA_I,
    input wire logic          WRITE_I,
    input wire logic          READ_I,
    input wire logic [DW-1:0] RDATA_O,
    input wire logic          CK_I,
    input wire logic          CK_O,
    input wire logic          CK_OE_O,
    input wire logic          DT_I,
    input wire logic          DT_O,
    input wire logic          DT_OE_O,
    input wire logic          IRQ_O
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DW-1:0] s_ctl, s_st, s_bd, s_ie;
    logic          wr_st;
    assign wr_st = WRITE_I && ADDR_I == OFS_STAT;
    // software view only; hardware clears are not mirrored
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            s_ctl <= RST_REG;
            s_st  <= RST_REG;
            s_bd  <= RST_REG;
            s_ie  <= RST_REG;
        end else if (WRITE_I) begin
            case (ADDR_I)
                OFS_CTRL: s_ctl <= WDATA_I;
                OFS_STAT: s_st <= WDATA_I;
                OFS_BAUD: s_bd <= WDATA_I;
                OFS_IEN:  s_ie <= WDATA_I;
                default:  ;
            endcase
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    property p_slave_ck;
        $stable({s_st[B_PE], s_ctl[B_MASTER]})
            |-> CK_OE_O == (s_st[B_PE] && s_ctl[B_MASTER]);
    endproperty
    a_slave_ck: assert property (p_slave_ck)
        else $error("clock driver enable wrong");
    property p_off;
        !s_st[B_PE] && !$past(s_st[B_PE]) |-> !DT_OE_O;
    endproperty
    a_off: assert property (p_off)
        else $error("data driver on while port disabled");
    property p_rx_rel;
        s_st[B_CONT] && $past(s_st[B_CONT]) |-> !DT_OE_O;
    endproperty
    a_rx_rel: assert property (p_rx_rel)
        else $error("data driver on during receive");
    property p_abort;
        wr_st && !WDATA_I[B_CONT] && !WDATA_I[B_SNGL] && WDATA_I[B_PE]
            && s_st[B_CONT] && s_st[B_PE] && s_ctl[B_MASTER]
            |-> ##2 (CK_O == s_ctl[B_POL]) [*6];
    endproperty
    a_abort: assert property (p_abort)
        else $error("clock not stopped after receive abort");
    property p_irq;
        IRQ_O && $stable(s_ie) |-> s_ie[B_GLB] && s_ie[B_PERI]
            && (s_ie[B_RXIR] || s_ie[B_TXIR]);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without its enables");
    property p_trail;
        CK_OE_O && DT_OE_O && $stable(s_ctl) && $changed(CK_O)
            && CK_O == s_ctl[B_POL] |-> $stable(DT_O);
    endproperty
    a_trail: assert property (p_trail)
        else $error("data moved on trailing clock edge");
    property p_half;
        CK_OE_O && $stable(s_ctl) && $changed(CK_O)
            && CK_O != s_ctl[B_POL] |=> $stable(CK_O) [*8];
    endproperty
    a_half: assert property (p_half)
        else $error("clock half period too short");
    property p_baud;
        READ_I && ADDR_I == OFS_BAUD |=> RDATA_O == s_bd;
    endproperty
    a_baud: assert property (p_baud)
        else $error("divisor readback wrong");
endmodule : usm_checker

bind usm_top usm_checker u_chk (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WRITE_I(WRITE_I), .READ_I(READ_I), .RDATA_O(RDATA_O), .CK_I(CK_I),
    .CK_O(CK_O), .CK_OE_O(CK_OE_O), .DT_I(DT_I), .DT_O(DT_O),
    .DT_OE_O(DT_OE_O), .IRQ_O(IRQ_O)
);

/* File: verification/usm_peer.sv */
// far-side serial controller model: clocks, talks, listens
module usm_peer (
    input  wire logic       ck_line_i,
    input  wire logic       dt_line_i,
    input  wire logic       pol_i,
    input  wire logic       clr_i,
    input  wire logic [8:0] word_i,
    output logic            ck_o,
    output logic            dt_o,
    output logic [8:0]      got_o,
    output int              lead_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int tix = 0;
    int rix = 0;
    initial ck_o = 1'b0;
    initial dt_o = 1'b0;
    always @(ck_line_i or posedge clr_i) begin
        if (clr_i) begin
            tix = 0;
            rix = 0;
            lead_o = 0;
            got_o = '0;
        end else if (ck_line_i != pol_i) begin
            lead_o++;
            dt_o = word_i[tix];
            tix = (tix + 1) % 9;
        end else begin
            got_o[rix] = dt_line_i;
            rix++;
        end
    end
    // clock stands still between frames
    task automatic frame(input int n);
        repeat (n) begin
            #100 ck_o = ~pol_i;
            #100 ck_o = pol_i;
        end
    endtask : frame
endmodule : usm_peer

/* File: verification/tb_top.sv */
// self-checking bench for the synchronous serial port
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top import usm_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic          CLK_I = 1'b0;
    logic          RESET_I = 1'b1;
    logic [AW-1:0] ADDR_I = '0;
    logic [DW-1:0] WDATA_I = '0;
    logic          WRITE_I = 1'b0;
    logic          READ_I = 1'b0;
    logic [DW-1:0] RDATA_O;
    logic          CK_O, CK_OE_O, DT_O, DT_OE_O, IRQ_O, pk_ck, pk_dt;
    logic          talk = 1'b0, clr = 1'b0, pol = 1'b0, dt_last = 1'b0;
    logic [8:0]    word = '0, got;
    logic [8:0]    wq [2];
    logic [15:0]   lf = 16'h3EBB;
    logic [7:0]    bd;
    int            lead, n_fail = 0, checks_done = 0;
    wire           ck_line = CK_OE_O ? CK_O : pk_ck;
    // undriven data line must not look like a held bit
    wire           dt_line = DT_OE_O ? DT_O : (talk ? pk_dt : ~dt_last);
    always #12.5 CLK_I = ~CLK_I;
    always @(posedge CLK_I) dt_last <= dt_line;
    usm_top u_dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WRITE_I(WRITE_I), .READ_I(READ_I),
        .RDATA_O(RDATA_O), .CK_I(ck_line), .CK_O(CK_O), .CK_OE_O(CK_OE_O),
        .DT_I(dt_line), .DT_O(DT_O), .DT_OE_O(DT_OE_O), .IRQ_O(IRQ_O));
    usm_peer u_peer (.ck_line_i(ck_line), .dt_line_i(dt_line),
        .pol_i(pol), .clr_i(clr), .word_i(word), .ck_o(pk_ck),
        .dt_o(pk_dt), .got_o(got), .lead_o(lead));
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WRITE_I <= 1'b1;
        @(posedge CLK_I);
        WRITE_I <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [2:0] a, input logic [7:0] m,
                         input logic [7:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        READ_I <= 1'b1;
        @(posedge CLK_I);
        READ_I <= 1'b0;
        @(negedge CLK_I);
        `CHK(RDATA_O & m, e)
    endtask : rdchk
    task automatic arm;
        repeat (3) @(posedge CLK_I);
        clr = 1'b1;
        #1 clr = 1'b0;
    endtask : arm
    task automatic wait_rx(input int n);
        for (int k = 0; k < 4000 && u_peer.rix < n; k++)
            @(posedge CLK_I);
        `CHK(u_peer.rix, n)
    endtask : wait_rx
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        #500us;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge CLK_I);
        RESET_I <= 1'b0;
        lf = nxt(lf);
        bd = 8'h06 + {6'h00, lf[1:0]};
        wr(OFS_BAUD, bd);
        rdchk(OFS_BAUD, 8'hFF, bd);
        rdchk(3'h7, 8'hFF, 8'h00);
        wr(OFS_IEN, 8'hC2);
        wr(OFS_STAT, 8'h80);
        arm();
        for (int i = 0; i < 2; i++) begin
            lf = nxt(lf);
            wq[i] = lf[8:0];
            wr(OFS_CTRL, 8'hE0 | {7'h00, lf[8]});
            wr(OFS_TXH, lf[7:0]);
        end
        for (int i = 0; i < 2; i++) begin
            wait_rx(9);
            `CHK(got, wq[i])
            arm();
        end
        `CHK(IRQ_O, 1'b1)
        wr(OFS_IEN, 8'h42);
        repeat (3) @(negedge CLK_I);
        `CHK(IRQ_O, 1'b0)
        // master single receive, clock idling high
        wr(OFS_STAT, 8'h00);
        pol = 1'b1;
        wr(OFS_CTRL, 8'h88);
        wr(OFS_IEN, 8'hC1);
        lf = nxt(lf);
        word = {1'b0, lf[7:0]};
        talk = 1'b1;
        wr(OFS_STAT, 8'hA0);
        arm();
        wait_rx(8);
        repeat (200) @(negedge CLK_I);
        `CHK(lead, 8)
        `CHK(IRQ_O, 1'b1)
        rdchk(OFS_STAT, 8'h20, 8'h00);
        rdchk(OFS_FLAG, 8'h01, 8'h01);
        rdchk(OFS_RXD, 8'hFF, word[7:0]);
        rdchk(OFS_FLAG, 8'h01, 8'h00);
        // continuous 9-bit receive runs into overflow
        lf = nxt(lf);
        word = lf[8:0];
        wr(OFS_STAT, 8'hF0);
        arm();
        wait_rx(27);
        repeat (200) @(posedge CLK_I);
        `CHK(lead, 27)
        rdchk(OFS_STAT, 8'h22, 8'h02);
        for (int i = 0; i < 2; i++) begin
            rdchk(OFS_RXD, 8'hFF, word[7:0]);
            rdchk(OFS_STAT, 8'h03, {7'h01, word[8]});
        end
        rdchk(OFS_FLAG, 8'h01, 8'h00);
        wr(OFS_STAT, 8'hC0);
        rdchk(OFS_STAT, 8'h02, 8'h00);
        // continuous enable cleared after three bits
        lf = nxt(lf);
        word = lf[8:0];
        wr(OFS_STAT, 8'h90);
        arm();
        wait_rx(3);
        wr(OFS_STAT, 8'h80);
        repeat (200) @(posedge CLK_I);
        `CHK(lead, 3)
        rdchk(OFS_FLAG, 8'h01, 8'h00);
        // slave: far side makes the clock
        wr(OFS_STAT, 8'h00);
        pol = 1'b0;
        wr(OFS_CTRL, 8'h00);
        wr(OFS_STAT, 8'h90);
        for (int i = 0; i < 2; i++) begin
            lf = nxt(lf);
            word = lf[8:0];
            arm();
            #7 u_peer.frame(8);
            repeat (20) @(posedge CLK_I);
            if (i == 0)
                rdchk(OFS_RXD, 8'hFF, word[7:0]);
        end
        `CHK(CK_OE_O, 1'b0)
        rdchk(OFS_FLAG, 8'h01, 8'h01);
        wr(OFS_STAT, 8'h00);
        rdchk(OFS_FLAG, 8'h01, 8'h00);
        talk = 1'b0;
        wr(OFS_CTRL, 8'h20);
        wr(OFS_STAT, 8'h80);
        lf = nxt(lf);
        wr(OFS_TXH, lf[7:0]);
        arm();
        #7 u_peer.frame(8);
        repeat (10) @(posedge CLK_I);
        `CHK(got[7:0], lf[7:0])
        end_of_test();
    end
endmodule : tb_top
